// >>> verilog/chb_pkg.sv
/*
 * chb_pkg: constants and state types for the per-channel slot gating bank.
 * Assumes an 8-bit register port with a byte address and one clock, clk_sys.
 */
`default_nettype none

package chb_pkg;

	// =========================================================================
	// register map
	// =========================================================================
	localparam logic [7:0] ADDR_RX_BLOCK_CH1_8   = 8'h88;
	localparam logic [7:0] ADDR_RX_BLOCK_CH9_16  = 8'h89;
	localparam logic [7:0] ADDR_RX_BLOCK_CH17_24 = 8'h8A;
	localparam logic [7:0] ADDR_RX_BLOCK_CH25_32 = 8'h8B;
	localparam logic [7:0] ADDR_TX_BLOCK_CH1_8   = 8'h8C;
	localparam logic [7:0] ADDR_TX_BLOCK_CH9_16  = 8'h8D;
	localparam logic [7:0] ADDR_TX_BLOCK_CH17_24 = 8'h8E;
	localparam logic [7:0] ADDR_TX_BLOCK_CH25_32 = 8'h8F;
	localparam logic [7:0] BLOCK_REG_RESET       = 8'h00;
	localparam logic [7:0] UNMAPPED_READ         = 8'h00;

	// =========================================================================
	// frame layout
	// =========================================================================
	localparam int         CHAN_W        = 5;
	localparam int         NUM_CHAN      = 32;
	localparam logic [4:0] T1_LAST_CHAN  = 5'h17;
	localparam logic [4:0] E1_LAST_CHAN  = 5'h1F;
	localparam logic [4:0] FIRST_CHAN    = 5'h00;
	localparam logic [4:0] CHAN_STEP     = 5'h01;
	localparam logic [31:0] T1_CHAN_MASK = 32'h00FF_FFFF;

	// =========================================================================
	// state types
	// =========================================================================
	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic              gate;
	} chb_gate_st_t;

	typedef struct packed {
		logic [NUM_CHAN-1:0] rxBlock;
		logic [NUM_CHAN-1:0] txBlock;
		logic [7:0]          rdData;
		logic                rdValid;
	} chb_bank_st_t;

endpackage : chb_pkg

`default_nettype wire

// >>> verilog/chb_slot_gate.sv
/*
 * chb_slot_gate: channel sequencer and gate output for one direction.
 * Assumes frameStart and slotStart are one-cycle pulses from that direction's
 * framer timing, synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module chb_slot_gate
	import chb_pkg::*;
(
	// clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// frame timing
	input  wire logic                    t1Mode,
	input  wire logic                    frameStart,
	input  wire logic                    slotStart,
	// per-channel levels
	input  wire logic [chb_pkg::NUM_CHAN-1:0] blockBits,
	// outputs
	output logic [chb_pkg::CHAN_W-1:0]   chanIdx,
	output logic                         gateOut
);
	import chb_pkg::*;

	chb_gate_st_t q;
	chb_gate_st_t d;
	logic [CHAN_W-1:0] lastChan;
	logic [NUM_CHAN-1:0] effBits;

	always_comb begin
		d        = q;
		lastChan = t1Mode ? T1_LAST_CHAN : E1_LAST_CHAN;
		// T1 has no slots past 24, so their bits never reach the pin
		effBits  = t1Mode ? (blockBits & T1_CHAN_MASK) : blockBits;
		if (frameStart) begin
			d.chan = FIRST_CHAN;
			d.gate = effBits[FIRST_CHAN];
		end else if (slotStart) begin
			// >= also recovers a count left past the end by a mode change
			d.chan = (q.chan >= lastChan) ? FIRST_CHAN : q.chan + CHAN_STEP;
			d.gate = effBits[d.chan];
		end
		// level is only sampled at a boundary, so it holds for the whole slot
		if (rst) begin
			d.chan = FIRST_CHAN;
			d.gate = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		q <= d;
	end

	assign chanIdx = q.chan;
	assign gateOut = q.gate;

endmodule // chb_slot_gate

`default_nettype wire

// >>> verilog/chb_channel_block.sv
/*
 * chb_channel_block: two banks of four 8-bit channel blocking registers and
 * the receive and transmit slot gate outputs they steer.
 * Assumes a simple synchronous register port (write strobe, read strobe,
 * byte address) and per-direction frame and slot pulses from the framer.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - A receive channel whose blocking bit is 1 drives the receive gate high for its whole slot.
// - A receive channel whose blocking bit is 0 keeps the receive gate low for its whole slot.
// - A transmit channel whose blocking bit is 1 drives the transmit gate high for its whole slot.
// - A transmit channel whose blocking bit is 0 keeps the transmit gate low for its whole slot.
// - In T1 mode the bits for channels 25 to 32 of both banks have no effect on the gates.
// - Receive bits live at 88h to 8Bh, eight channels each, lowest channel at bit 0.
// - Transmit bits live at 8Ch to 8Fh, eight channels each, lowest channel at bit 0.
// - Every channel's level is programmed on its own, so any mix per frame is possible.
// - The sequencer walks 24 slots per frame in T1 mode and 32 slots in E1 mode.
module chb_channel_block
	import chb_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrEn,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regRdEn,
	output logic [7:0]       regRdData,
	output logic             regRdValid,
	// line mode
	input  wire logic        t1Mode,
	// receive frame timing
	input  wire logic        rxFrameStart,
	input  wire logic        rxSlotStart,
	// transmit frame timing
	input  wire logic        txFrameStart,
	input  wire logic        txSlotStart,
	// gate outputs
	output logic             rxSlotGateOut,
	output logic             txSlotGateOut
);
	import chb_pkg::*;

	// =========================================================================
	// register bank
	// =========================================================================
	chb_bank_st_t q;
	chb_bank_st_t d;
	logic         hitRx;
	logic         hitTx;
	logic [1:0]   lane;

	always_comb begin
		d     = q;
		hitRx = (regAddr[7:2] == ADDR_RX_BLOCK_CH1_8[7:2]);
		hitTx = (regAddr[7:2] == ADDR_TX_BLOCK_CH1_8[7:2]);
		lane  = regAddr[1:0];
		if (regWrEn && hitRx) begin
			d.rxBlock[{lane, 3'h0} +: 8] = regWrData;
		end
		if (regWrEn && hitTx) begin
			d.txBlock[{lane, 3'h0} +: 8] = regWrData;
		end
		// a read in the same cycle as a write returns the old contents
		d.rdValid = regRdEn;
		if (regRdEn) begin
			if (hitRx) begin
				d.rdData = q.rxBlock[{lane, 3'h0} +: 8];
			end else if (hitTx) begin
				d.rdData = q.txBlock[{lane, 3'h0} +: 8];
			end else begin
				d.rdData = UNMAPPED_READ;
			end
		end
		if (rst) begin
			d.rxBlock = {4{BLOCK_REG_RESET}};
			d.txBlock = {4{BLOCK_REG_RESET}};
			d.rdData  = UNMAPPED_READ;
			d.rdValid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		q <= d;
	end

	assign regRdData  = q.rdData;
	assign regRdValid = q.rdValid;

	// =========================================================================
	// per-direction slot gates
	// =========================================================================
	logic [CHAN_W-1:0] rxChan;
	logic [CHAN_W-1:0] txChan;

	chb_slot_gate u_rxGate (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.t1Mode     (t1Mode),
		.frameStart (rxFrameStart),
		.slotStart  (rxSlotStart),
		.blockBits  (q.rxBlock),
		.chanIdx    (rxChan),
		.gateOut    (rxSlotGateOut)
	);

	chb_slot_gate u_txGate (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.t1Mode     (t1Mode),
		.frameStart (txFrameStart),
		.slotStart  (txSlotStart),
		.blockBits  (q.txBlock),
		.chanIdx    (txChan),
		.gateOut    (txSlotGateOut)
	);

	// =========================================================================
	// checks
	// =========================================================================
	logic [NUM_CHAN-1:0] rxEffPast;
	logic [NUM_CHAN-1:0] txEffPast;
	logic                rxBound;
	logic                txBound;

	assign rxBound = rxFrameStart || rxSlotStart;
	assign txBound = txFrameStart || txSlotStart;

	// bits as the gate saw them at the boundary edge
	always_ff @(posedge clk_sys) begin
		rxEffPast <= t1Mode ? (q.rxBlock & T1_CHAN_MASK) : q.rxBlock;
		txEffPast <= t1Mode ? (q.txBlock & T1_CHAN_MASK) : q.txBlock;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	property p_rx_high;
		rxBound |=> (!rxEffPast[rxChan] || rxSlotGateOut);
	endproperty
	a_rx_high: assert property (p_rx_high)
		else $error("receive gate low in a blocked slot");

	property p_rx_low;
		rxBound |=> (rxEffPast[rxChan] || !rxSlotGateOut);
	endproperty
	a_rx_low: assert property (p_rx_low)
		else $error("receive gate high in an open slot");

	property p_tx_high;
		txBound |=> (!txEffPast[txChan] || txSlotGateOut);
	endproperty
	a_tx_high: assert property (p_tx_high)
		else $error("transmit gate low in a blocked slot");

	property p_tx_low;
		txBound |=> (txEffPast[txChan] || !txSlotGateOut);
	endproperty
	a_tx_low: assert property (p_tx_low)
		else $error("transmit gate high in an open slot");

	property p_t1_range;
		(t1Mode && rxSlotStart && !rxFrameStart && rxChan == T1_LAST_CHAN)
			|=> (rxChan == FIRST_CHAN && (!rxSlotGateOut || $past(q.rxBlock[0])));
	endproperty
	a_t1_range: assert property (p_t1_range)
		else $error("T1 receive sequencer ran past channel 24");

	sequence s_rx_write;
		regWrEn && hitRx && !regRdEn;
	endsequence
	sequence s_same_read;
		regRdEn && !regWrEn && regAddr == $past(regAddr);
	endsequence

	property p_rx_readback;
		s_rx_write ##1 s_same_read |=> (regRdValid && regRdData == $past(regWrData, 2));
	endproperty
	a_rx_readback: assert property (p_rx_readback)
		else $error("receive blocking register did not read back");

	property p_tx_readback;
		(regWrEn && hitTx && !regRdEn) ##1 s_same_read
			|=> (regRdValid && regRdData == $past(regWrData, 2));
	endproperty
	a_tx_readback: assert property (p_tx_readback)
		else $error("transmit blocking register did not read back");

	property p_unmapped;
		(regRdEn && !hitRx && !hitTx) |=> (regRdValid && regRdData == UNMAPPED_READ);
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_lane_only;
		(regWrEn && regAddr == ADDR_RX_BLOCK_CH1_8)
			|=> (q.rxBlock[31:8] == $past(q.rxBlock[31:8])
				&& q.rxBlock[7:0] == $past(regWrData)
				&& q.txBlock == $past(q.txBlock));
	endproperty
	a_lane_only: assert property (p_lane_only)
		else $error("write disturbed another channel group");

	property p_e1_wrap;
		(!t1Mode && txSlotStart && !txFrameStart && txChan == E1_LAST_CHAN)
			|=> (txChan == FIRST_CHAN);
	endproperty
	a_e1_wrap: assert property (p_e1_wrap)
		else $error("E1 transmit sequencer did not wrap after 32 slots");

	property p_frame_first;
		txFrameStart |=> (txChan == FIRST_CHAN);
	endproperty
	a_frame_first: assert property (p_frame_first)
		else $error("frame start did not select channel 1");

	property p_rx_hold;
		!rxBound |=> $stable(rxSlotGateOut);
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("receive gate moved inside a slot");

	property p_tx_hold;
		!txBound |=> $stable(txSlotGateOut);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("transmit gate moved inside a slot");

endmodule // chb_channel_block

`default_nettype wire

// >>> sim/chb_frame_model.sv
/*
 * chb_frame_model: framer timing source and gated-controller observer for one direction.
 * Assumes a gate from chb_channel_block on the same clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module chb_frame_model
	import chb_pkg::*;
#(
	parameter int SLOT_LEN = 4
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// control and gate
	input  wire logic        run,
	input  wire logic        t1Mode,
	input  wire logic        freeWrap,
	input  wire logic        gate,
	// timing pulses
	output logic             frameStart,
	output logic             slotStart,
	// observations
	output logic [31:0]      seen,
	output logic [7:0]       frameCnt,
	output logic             glitch
);
	import chb_pkg::*;
	int         cyc;
	logic [4:0] idx;
	logic       armed;
	logic       first;
	logic       isFrame;
	logic [4:0] last;
	// free wrap leaves later frames to the design's own slot count
	assign isFrame = (idx == FIRST_CHAN) && !(freeWrap && armed);
	assign last    = t1Mode ? T1_LAST_CHAN : E1_LAST_CHAN;
	always @(posedge clk_sys) begin
		if (rst || !run) begin
			cyc        <= 0;
			idx        <= FIRST_CHAN;
			armed      <= 1'b0;
			frameStart <= 1'b0;
			slotStart  <= 1'b0;
			seen       <= 32'h0000_0000;
			frameCnt   <= 8'h00;
			glitch     <= 1'b0;
		end else begin
			frameStart <= (cyc == 0) && isFrame;
			slotStart  <= (cyc == 0) && !isFrame;
			cyc        <= (cyc == SLOT_LEN - 1) ? 0 : cyc + 1;
			if (cyc == SLOT_LEN - 1)
				idx <= (idx == last) ? FIRST_CHAN : idx + CHAN_STEP;
			// gate is due two cycles after the slot starts and must hold to the next one
			if (cyc == 2) begin
				seen[idx] <= gate;
				first     <= gate;
				armed     <= 1'b1;
				if (idx == last)
					frameCnt <= frameCnt + 8'h01;
			end else if (armed && gate !== first)
				glitch <= 1'b1;
		end
	end
endmodule // chb_frame_model

`default_nettype wire

// >>> sim/tb.sv
/*
 * tb: register and frame-gating scenarios for chb_channel_block.
 * Assumes two chb_frame_model instances stand in for the framer and controller.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	import chb_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic       regWrEn = 1'b0;
	logic [7:0] regWrData = 8'h00;
	logic       regRdEn = 1'b0;
	logic [7:0] regRdData;
	logic       regRdValid;
	logic       t1Mode = 1'b0;
	logic       run = 1'b0;
	logic       freeWrap = 1'b0;
	logic       rxFs, rxSs, txFs, txSs, rxGate, txGate, rxGl, txGl;
	logic [31:0] rxSeen, txSeen;
	logic [7:0] rxCnt, txCnt;
	int         miscompares = 0;
	int         compares = 0;
	int         cycles = 0;

	always #25 clk_sys = ~clk_sys;

	chb_channel_block u_chb_channel_block (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .t1Mode(t1Mode), .rxFrameStart(rxFs), .rxSlotStart(rxSs),
		.txFrameStart(txFs), .txSlotStart(txSs), .rxSlotGateOut(rxGate), .txSlotGateOut(txGate));
	chb_frame_model #(.SLOT_LEN(4)) u_rx_model (.clk_sys(clk_sys), .rst(rst), .run(run),
		.t1Mode(t1Mode), .freeWrap(freeWrap), .gate(rxGate), .frameStart(rxFs),
		.slotStart(rxSs), .seen(rxSeen), .frameCnt(rxCnt), .glitch(rxGl));
	chb_frame_model #(.SLOT_LEN(3)) u_tx_model (.clk_sys(clk_sys), .rst(rst), .run(run),
		.t1Mode(t1Mode), .freeWrap(freeWrap), .gate(txGate), .frameStart(txFs),
		.slotStart(txSs), .seen(txSeen), .frameCnt(txCnt), .glitch(txGl));

	task automatic report_and_stop;
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr   = a;
		regWrData = d;
		regWrEn   = 1'b1;
		@(posedge clk_sys);
		#1;
		regWrEn = 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	// answer is due on the read edge itself and is checked 1ns after it
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge clk_sys);
		#1;
		regRdEn = 1'b0;
		chk("regRdValid", 32'h1, {31'h0, regRdValid});
		chk("regRdData", {24'h0, exp}, {24'h0, regRdData});
		@(posedge clk_sys);
		#1;
	endtask

	// write then read in the next cycle, then a read that meets a write at one address
	task automatic t_back_to_back;
		regAddr   = ADDR_RX_BLOCK_CH9_16;
		regWrData = 8'h3C;
		regWrEn   = 1'b1;
		@(posedge clk_sys);
		#1;
		regWrEn = 1'b0;
		regRdEn = 1'b1;
		@(posedge clk_sys);
		#1;
		regRdEn = 1'b0;
		chk("rx readback valid", 32'h1, {31'h0, regRdValid});
		chk("rx readback", 32'h3C, {24'h0, regRdData});
		regAddr   = ADDR_TX_BLOCK_CH25_32;
		regWrData = 8'hC3;
		regWrEn   = 1'b1;
		@(posedge clk_sys);
		#1;
		regWrEn = 1'b0;
		regRdEn = 1'b1;
		@(posedge clk_sys);
		#1;
		regWrData = 8'h5A;
		regWrEn   = 1'b1;
		chk("tx readback", 32'hC3, {24'h0, regRdData});
		@(posedge clk_sys);
		#1;
		regWrEn = 1'b0;
		// the read taken with the write still returns the old contents
		chk("tx read with write", 32'hC3, {24'h0, regRdData});
		@(posedge clk_sys);
		#1;
		regRdEn = 1'b0;
		chk("tx after write", 32'h5A, {24'h0, regRdData});
		@(posedge clk_sys);
		#1;
	endtask

	task automatic load_banks(input logic [31:0] rx, input logic [31:0] tx);
		for (int i = 0; i < 4; i++) begin
			wr(8'(ADDR_RX_BLOCK_CH1_8 + i), rx[8*i +: 8]);
			wr(8'(ADDR_TX_BLOCK_CH1_8 + i), tx[8*i +: 8]);
		end
		wr(8'h90, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			rd(8'(ADDR_RX_BLOCK_CH1_8 + i), rx[8*i +: 8]);
			rd(8'(ADDR_TX_BLOCK_CH1_8 + i), tx[8*i +: 8]);
		end
		rd(8'h90, UNMAPPED_READ);
	endtask

	task automatic t_reset;
		for (int i = 0; i < 8; i++)
			rd(8'(ADDR_RX_BLOCK_CH1_8 + i), BLOCK_REG_RESET);
		rd(8'h87, UNMAPPED_READ);
		chk("gates", 32'h0, {30'h0, rxGate, txGate});
	endtask

	task automatic t_frame(input logic t1, input logic fw, input logic [31:0] rx,
		input logic [31:0] tx);
		logic [31:0] m;
		m = t1 ? T1_CHAN_MASK : 32'hFFFF_FFFF;
		load_banks(rx, tx);
		t1Mode   = t1;
		freeWrap = fw;
		run      = 1'b1;
		for (int n = 0; n < 2000 && rxCnt < 8'h03; n++)
			@(posedge clk_sys);
		#1;
		chk("rx slots", rx & m, rxSeen);
		chk("tx slots", tx & m, txSeen);
		chk("glitch", 32'h0, {30'h0, rxGl, txGl});
		chk("rx frames", 32'h3, {24'h0, rxCnt});
		// rewrite while running: the gates may only move at slot boundaries
		wr(ADDR_RX_BLOCK_CH1_8, ~rx[7:0]);
		wr(ADDR_TX_BLOCK_CH1_8, ~tx[7:0]);
		chk("glitch after write", 32'h0, {30'h0, rxGl, txGl});
		run = 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_reset();
		t_back_to_back();
		t_frame(1'b0, 1'b0, 32'hA5C3_0F96, 32'h5A3C_F069);
		t_frame(1'b1, 1'b1, 32'hFE5A_3C81, 32'hFF81_C35A);
		t_frame(1'b0, 1'b1, 32'hFFFF_FFFF, 32'h8000_0001);
		report_and_stop();
	end
endmodule // tb

`default_nettype wire
